// *** include/icc_pkg.sv ***
// Constants shared by the instruction cache control block.
// Assumes a single core clock domain and 24-bit program addresses.
package icc_pkg;
    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W  = 24;
    localparam int INSTR_W = 48;
    localparam int INDEX_W = 4;
    localparam int SETS    = 16;
    localparam int WAYS    = 2;
    localparam int ENT_W   = INDEX_W + 1;
    localparam int ENTRIES = SETS * WAYS;
    localparam int TAG_W   = ADDR_W - INDEX_W;
    localparam int MODE_W  = 32;

    // ----------------------------------------------------------------
    // Mode register fields and reset value
    // ----------------------------------------------------------------
    localparam int               CACHE_OFF_POS = 4;
    localparam int               EXT_OFF_POS   = 6;
    localparam int               HOLD_POS      = 19;
    localparam logic [MODE_W-1:0] MODE_RST     = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Latencies in core cycles
    // ----------------------------------------------------------------
    localparam int HOLD_LAT      = 2;
    localparam int FLUSH_LAT_INT = 1;
    localparam int FLUSH_LAT_EXT = 2;

    // Invalidate stall sequencer
    typedef enum logic [1:0] {
        FL_IDLE  = 2'b00,
        FL_WAIT1 = 2'b01,
        FL_WAIT2 = 2'b10
    } icc_flush_t;
endpackage : icc_pkg

// *** verilog/icc_data_mem.sv ***
// Instruction data store of the cache, one word per way and set.
// Assumes write and read come from the same core clock; read is registered.
`timescale 1ns/1ps
`default_nettype none
module icc_data_mem #(
    parameter int WIDTH  = 48,
    parameter int DEPTH  = 32,
    parameter int AWIDTH = 5
) (
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    input  wire logic              wr_en,
    input  wire logic [AWIDTH-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]  wr_data,
    input  wire logic              rd_en,
    input  wire logic [AWIDTH-1:0] rd_addr,
    output logic      [WIDTH-1:0]  rd_data
);
    logic [WIDTH-1:0] mem_r [0:DEPTH-1];
    logic [WIDTH-1:0] rd_data_nxt;

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    // Read-before-write: the caller forwards a same-cycle write itself
    always_comb begin
        rd_data_nxt = rd_en ? mem_r[rd_addr] : rd_data;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_data <= '0;
        end else begin
            rd_data <= rd_data_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Write port
    // ----------------------------------------------------------------
    // Contents need no reset; valid bits live with the tags
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end
endmodule // icc_data_mem
`default_nettype wire

// *** verilog/icc_cache_ctrl.sv ***
// Two-way set-associative instruction cache with LRU, mode bits and flush.
// Assumes fetch, collision and mode-write strobes come from core-clock logic.
`timescale 1ns/1ps
`default_nettype none
module icc_cache_ctrl
    import icc_pkg::*;
(
    input  wire logic                       clk_sys,
    input  wire logic                       sys_rst,
    input  wire logic                       fetch_valid,
    input  wire logic [icc_pkg::ADDR_W-1:0] fetch_addr,
    input  wire logic                       fetch_is_ext,
    input  wire logic                       pm_collide,
    input  wire logic [icc_pkg::INSTR_W-1:0] program_mem_data_bus,
    input  wire logic                       mode_wr_en,
    input  wire logic [icc_pkg::MODE_W-1:0] mode_wr_data,
    input  wire logic                       flush_req,
    input  wire logic                       flush_next_ext,
    output logic [icc_pkg::MODE_W-1:0]      core_mode_reg_two,
    output logic                            fetch_stall,
    output logic                            flush_stall,
    output logic                            cache_hit,
    output logic [icc_pkg::INSTR_W-1:0]     instr_out
);
    import icc_pkg::*;

    logic [MODE_W-1:0]  mode_r, mode_nxt;
    logic [HOLD_LAT-1:0] hold_dly_r, hold_dly_nxt;
    logic               cache_off_bit, external_cache_off_bit, cache_hold_bit;
    icc_flush_t         flush_st_r, flush_st_nxt;
    logic               flush_go;
    logic [TAG_W-1:0]   tag_r [0:ENTRIES-1];
    logic [TAG_W-1:0]   tag_nxt [0:ENTRIES-1];
    logic [ENTRIES-1:0] valid_r, valid_nxt;
    logic [SETS-1:0]    lru_r, lru_nxt;
    logic [INDEX_W-1:0] set_idx;
    logic [TAG_W-1:0]   fetch_tag;
    logic               lookup, hit, hit_way, victim, alloc;
    logic [ENT_W-1:0]   hit_ent, alloc_ent;
    logic               pend_r, pend_nxt;
    logic [ENT_W-1:0]   pend_ent_r, pend_ent_nxt;
    logic               hit_r, hit_nxt, byp_r, byp_nxt;
    logic [INSTR_W-1:0] byp_data_r, byp_data_nxt, mem_q;

    // ----------------------------------------------------------------
    // Mode register and freeze latency
    // ----------------------------------------------------------------
    // Freeze passes a second stage so it bites two instructions after the write
    always_comb begin
        mode_nxt     = mode_wr_en ? mode_wr_data : mode_r;
        hold_dly_nxt = {hold_dly_r[HOLD_LAT-2:0], mode_nxt[HOLD_POS]};
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mode_r     <= MODE_RST;
            hold_dly_r <= '0;
        end else begin
            mode_r     <= mode_nxt;
            hold_dly_r <= hold_dly_nxt;
        end
    end

    assign cache_off_bit          = mode_r[CACHE_OFF_POS];
    assign external_cache_off_bit = mode_r[EXT_OFF_POS];
    assign cache_hold_bit         = hold_dly_r[HOLD_LAT-1];
    assign core_mode_reg_two      = mode_r;

    // ----------------------------------------------------------------
    // Invalidate sequencer
    // ----------------------------------------------------------------
    // Requests during the stall are dropped; the core is held anyway
    assign flush_go    = flush_req && (flush_st_r == FL_IDLE);
    assign flush_stall = (flush_st_r != FL_IDLE);

    always_comb begin
        case (flush_st_r)
            FL_IDLE: begin
                if (flush_go) begin
                    flush_st_nxt = flush_next_ext ? FL_WAIT2 : FL_WAIT1;
                end else begin
                    flush_st_nxt = FL_IDLE;
                end
            end
            FL_WAIT2: flush_st_nxt = FL_WAIT1;
            FL_WAIT1: flush_st_nxt = FL_IDLE;
            default:  flush_st_nxt = FL_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flush_st_r <= FL_IDLE;
        end else begin
            flush_st_r <= flush_st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Lookup and hit detection
    // ----------------------------------------------------------------
    // Low address bits pick the set, so 0x104/0x204/0x214 collide
    assign set_idx   = fetch_addr[INDEX_W-1:0];
    assign fetch_tag = fetch_addr[ADDR_W-1:INDEX_W];

    // Disabled cache holds colliding internal fetches instead of looking up
    assign fetch_stall = fetch_valid && pm_collide && !fetch_is_ext && cache_off_bit;
    assign lookup = fetch_valid && !cache_off_bit && !flush_stall && !flush_go
                    && (fetch_is_ext ? !external_cache_off_bit : pm_collide);

    always_comb begin
        hit     = 1'b0;
        hit_way = 1'b0;
        for (int w = 0; w < WAYS; w++) begin
            if (valid_r[{set_idx, w[0]}] && tag_r[{set_idx, w[0]}] == fetch_tag) begin
                hit     = lookup;
                hit_way = w[0];
            end
        end
    end

    // Empty way first, otherwise the least recently used one
    assign victim    = !valid_r[{set_idx, 1'b0}] ? 1'b0 :
                       !valid_r[{set_idx, 1'b1}] ? 1'b1 : lru_r[set_idx];
    assign hit_ent   = {set_idx, hit_way};
    assign alloc_ent = {set_idx, victim};
    assign alloc     = lookup && !hit && !cache_hold_bit;

    // ----------------------------------------------------------------
    // Tag, valid and LRU state
    // ----------------------------------------------------------------
    always_comb begin
        tag_nxt   = tag_r;
        valid_nxt = valid_r;
        lru_nxt   = lru_r;
        if (flush_go) begin
            valid_nxt = '0;
        end else if (alloc) begin
            tag_nxt[alloc_ent]   = fetch_tag;
            valid_nxt[alloc_ent] = 1'b1;
            lru_nxt[set_idx]     = ~victim;
        end else if (hit) begin
            lru_nxt[set_idx]     = ~hit_way;
        end
    end

    // Tags need no reset: valid bits gate them
    always_ff @(posedge clk_sys) begin
        tag_r <= tag_nxt;
        if (sys_rst) begin
            valid_r <= '0;
            lru_r   <= '0;
        end else begin
            valid_r <= valid_nxt;
            lru_r   <= lru_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Data fill and read-out
    // ----------------------------------------------------------------
    // Fetched word arrives on the bus one cycle after the miss; a hit on the
    // entry being filled that cycle takes the bus word, the store is stale
    always_comb begin
        pend_nxt     = alloc;
        pend_ent_nxt = alloc ? alloc_ent : pend_ent_r;
        hit_nxt      = hit;
        byp_nxt      = hit && pend_r && (pend_ent_r == hit_ent);
        byp_data_nxt = byp_nxt ? program_mem_data_bus : byp_data_r;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pend_r     <= 1'b0;
            pend_ent_r <= '0;
            hit_r      <= 1'b0;
            byp_r      <= 1'b0;
            byp_data_r <= '0;
        end else begin
            pend_r     <= pend_nxt;
            pend_ent_r <= pend_ent_nxt;
            hit_r      <= hit_nxt;
            byp_r      <= byp_nxt;
            byp_data_r <= byp_data_nxt;
        end
    end

    icc_data_mem #(
        .WIDTH  (INSTR_W),
        .DEPTH  (ENTRIES),
        .AWIDTH (ENT_W)
    ) u_data_mem (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .wr_en   (pend_r),
        .wr_addr (pend_ent_r),
        .wr_data (program_mem_data_bus),
        .rd_en   (hit),
        .rd_addr (hit_ent),
        .rd_data (mem_q)
    );

    assign cache_hit = hit_r;
    assign instr_out = byp_r ? byp_data_r : mem_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_reset_clear: assert property (@(posedge clk_sys) disable iff (1'b0)
        sys_rst |=> (valid_r == '0 && lru_r == '0)) else $error("reset left state");
    a_miss_fill: assert property (alloc |=> valid_r[$past(alloc_ent)]
        && pend_r && pend_ent_r == $past(alloc_ent)) else $error("miss not filled");
    a_lru_victim: assert property (alloc && (&valid_r[{set_idx, 1'b0} +: 2])
        |-> victim == lru_r[set_idx]) else $error("victim not lru way");
    a_collide_load: assert property (fetch_valid && !fetch_is_ext && pm_collide
        && !cache_off_bit && !cache_hold_bit && !flush_stall && !flush_go && !hit
        |=> valid_r[$past(alloc_ent)]) else $error("collision not loaded");
    a_set_four: assert property (fetch_addr == 24'h000214 |-> set_idx == 4'h4)
        else $error("bad set index");
    a_off_stall: assert property (fetch_valid && !fetch_is_ext && pm_collide
        && mode_r[CACHE_OFF_POS] |-> fetch_stall && !lookup) else $error("off not stalled");
    a_ext_off: assert property (fetch_is_ext && mode_r[EXT_OFF_POS] |-> !lookup)
        else $error("external cached while off");
    a_hold_keep: assert property (lookup && !hit && cache_hold_bit
        |=> valid_r == $past(valid_r) && !pend_r) else $error("frozen cache changed");
    a_hold_lat: assert property (mode_wr_en |-> ##2
        cache_hold_bit == $past(mode_wr_data[HOLD_POS], 2)) else $error("freeze latency");
    a_flush_ext: assert property (flush_go && flush_next_ext |=> flush_stall
        ##1 flush_stall ##1 !flush_stall) else $error("external flush latency");
    a_flush_int: assert property (flush_go && !flush_next_ext |=> flush_stall
        ##1 !flush_stall) else $error("internal flush latency");
    a_int_nolook: assert property (!fetch_is_ext && !pm_collide |-> !lookup)
        else $error("internal lookup without collision");
    a_flush_clear: assert property (flush_go |=> valid_r == '0)
        else $error("flush left valid bits");
    a_hit_tag: assert property (hit |-> valid_r[hit_ent]
        && tag_r[hit_ent] == fetch_tag) else $error("false hit");
    a_hit_lru: assert property (hit |=> hit_r
        && lru_r[$past(set_idx)] == ~$past(hit_way)) else $error("lru not updated");

    c_hit:       cover property (hit ##1 cache_hit);
    c_fill_hit:  cover property (alloc ##1 (hit && byp_nxt));
    c_ext_flush: cover property (flush_go && flush_next_ext);
    c_stall:     cover property (fetch_stall);
endmodule // icc_cache_ctrl
`default_nettype wire

// *** tb/icc_mem_model.sv ***
// Memory model on the far side of the cache: answers every fetch with a word.
// Assumes fetches are launched on the rising edge of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module icc_mem_model
    import icc_pkg::*;
(
    input  wire logic                        clk_sys,
    input  wire logic                        sys_rst,
    input  wire logic                        fetch_valid,
    input  wire logic [icc_pkg::ADDR_W-1:0]  fetch_addr,
    output logic      [icc_pkg::INSTR_W-1:0] program_mem_data_bus
);
    import icc_pkg::*;
    // Word is {~addr, addr} in Fetch2; each idle cycle inverts it, so stale data matches again after an even number of idle cycles
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            program_mem_data_bus <= '0;
        end else if (fetch_valid) begin
            program_mem_data_bus <= {~fetch_addr, fetch_addr};
        end else begin
            program_mem_data_bus <= ~program_mem_data_bus;
        end
    end
endmodule // icc_mem_model
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the instruction cache control block.
// Assumes icc_pkg and the memory model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import icc_pkg::*;
    logic                clk_sys, sys_rst, fetch_valid, fetch_is_ext, pm_collide;
    logic                mode_wr_en, flush_req, flush_next_ext;
    logic                fetch_stall, flush_stall, cache_hit;
    logic [ADDR_W-1:0]   fetch_addr;
    logic [INSTR_W-1:0]  program_mem_data_bus, instr_out;
    logic [MODE_W-1:0]   mode_wr_data, core_mode_reg_two;
    int                  n_mismatch = 0;
    int                  num_checks = 0;

    icc_cache_ctrl i_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .fetch_valid(fetch_valid),
        .fetch_addr(fetch_addr), .fetch_is_ext(fetch_is_ext), .pm_collide(pm_collide),
        .program_mem_data_bus(program_mem_data_bus), .mode_wr_en(mode_wr_en),
        .mode_wr_data(mode_wr_data), .flush_req(flush_req),
        .flush_next_ext(flush_next_ext), .core_mode_reg_two(core_mode_reg_two),
        .fetch_stall(fetch_stall), .flush_stall(flush_stall),
        .cache_hit(cache_hit), .instr_out(instr_out)
    );
    icc_mem_model i_mem (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .fetch_valid(fetch_valid),
        .fetch_addr(fetch_addr), .program_mem_data_bus(program_mem_data_bus)
    );

    // 40 MHz core clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // Compare and drive helpers
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic chk_word(input logic [47:0] got, input logic [47:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic drive(input logic v, input logic [23:0] a, input logic e, input logic c);
        fetch_valid <= v;
        fetch_addr <= a;
        fetch_is_ext <= e;
        pm_collide <= c;
    endtask
    // One fetch with an idle cycle after it; the hit shows one cycle after the lookup
    task automatic fetch(input logic [23:0] a, input logic e, input logic c, input logic h,
                         input logic s);
        @(posedge clk_sys);
        drive(1'b1, a, e, c);
        #1 chk_bit(fetch_stall, s, "fetch stall");
        @(posedge clk_sys);
        drive(1'b0, a, 1'b0, 1'b0);
        #1 chk_bit(cache_hit, h, "cache hit");
        if (h) chk_word(instr_out, {~a, a}, "hit word");
    endtask
    task automatic mode_wr(input logic [31:0] d);
        @(posedge clk_sys);
        mode_wr_en <= 1'b1;
        mode_wr_data <= d;
        @(posedge clk_sys);
        mode_wr_en <= 1'b0;
        #1 chk_word({16'h0000, core_mode_reg_two}, {16'h0000, d}, "mode readback");
    endtask
    task automatic flush(input logic e, input int n);
        @(posedge clk_sys);
        flush_req <= 1'b1;
        flush_next_ext <= e;
        @(posedge clk_sys);
        flush_req <= 1'b0;
        for (int i = 0; i < n; i++) begin
            #1 chk_bit(flush_stall, 1'b1, "flush stall high");
            @(posedge clk_sys);
        end
        #1 chk_bit(flush_stall, 1'b0, "flush stall low");
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_reset();
        chk_bit(cache_hit | flush_stall, 1'b0, "reset outputs");
        fetch(24'h104, 1'b0, 1'b1, 1'b0, 1'b0);
        fetch(24'h104, 1'b0, 1'b1, 1'b1, 1'b0);
        fetch(24'h105, 1'b0, 1'b0, 1'b0, 1'b0);
        fetch(24'h105, 1'b0, 1'b0, 1'b0, 1'b0);
        fetch(24'h300, 1'b1, 1'b0, 1'b0, 1'b0);
        fetch(24'h300, 1'b1, 1'b0, 1'b1, 1'b0);
    endtask
    task automatic sc_lru();
        fetch(24'h204, 1'b0, 1'b1, 1'b0, 1'b0);
        fetch(24'h104, 1'b0, 1'b1, 1'b1, 1'b0);
        fetch(24'h214, 1'b0, 1'b1, 1'b0, 1'b0);
        fetch(24'h104, 1'b0, 1'b1, 1'b1, 1'b0);
        fetch(24'h204, 1'b0, 1'b1, 1'b0, 1'b0);
        fetch(24'h214, 1'b0, 1'b1, 1'b0, 1'b0);
    endtask
    // Miss then same address next cycle: served from the load bus
    task automatic sc_bypass();
        @(posedge clk_sys);
        drive(1'b1, 24'h123, 1'b0, 1'b1);
        @(posedge clk_sys);
        #1 chk_bit(cache_hit, 1'b0, "first miss");
        @(posedge clk_sys);
        drive(1'b0, 24'h123, 1'b0, 1'b0);
        #1 chk_bit(cache_hit, 1'b1, "bypass hit");
        chk_word(instr_out, {~24'h123, 24'h123}, "bypass word");
    endtask
    // Mode write is always followed by a cycle without a data access
    task automatic sc_off();
        mode_wr(32'h0000_0010);
        fetch(24'h104, 1'b0, 1'b1, 1'b0, 1'b1);
        fetch(24'h300, 1'b1, 1'b0, 1'b0, 1'b0);
        mode_wr(32'h0000_0000);
        fetch(24'h104, 1'b0, 1'b1, 1'b0, 1'b0);
        fetch(24'h104, 1'b0, 1'b1, 1'b1, 1'b0);
        mode_wr(32'h0000_0040);
        fetch(24'h300, 1'b1, 1'b0, 1'b0, 1'b0);
        fetch(24'h104, 1'b0, 1'b1, 1'b1, 1'b0);
        mode_wr(32'h0000_0000);
        fetch(24'h300, 1'b1, 1'b0, 1'b1, 1'b0);
    endtask
    // Fetches in the write cycle and the next still allocate; the third does not
    task automatic sc_freeze();
        @(posedge clk_sys);
        mode_wr_en <= 1'b1;
        mode_wr_data <= 32'h0008_0000;
        drive(1'b1, 24'h147, 1'b0, 1'b1);
        @(posedge clk_sys);
        mode_wr_en <= 1'b0;
        drive(1'b1, 24'h158, 1'b0, 1'b1);
        @(posedge clk_sys);
        drive(1'b1, 24'h169, 1'b0, 1'b1);
        @(posedge clk_sys);
        drive(1'b0, 24'h169, 1'b0, 1'b0);
        fetch(24'h147, 1'b0, 1'b1, 1'b1, 1'b0);
        fetch(24'h158, 1'b0, 1'b1, 1'b1, 1'b0);
        fetch(24'h169, 1'b0, 1'b1, 1'b0, 1'b0);
        mode_wr(32'h0000_0000);
        fetch(24'h169, 1'b0, 1'b1, 1'b0, 1'b0);
        fetch(24'h169, 1'b0, 1'b1, 1'b1, 1'b0);
    endtask
    task automatic sc_flush();
        mode_wr(32'h0000_0010);
        flush(1'b0, 1);
        mode_wr(32'h0000_0000);
        fetch(24'h104, 1'b0, 1'b1, 1'b0, 1'b0);
        fetch(24'h104, 1'b0, 1'b1, 1'b1, 1'b0);
        flush(1'b1, 2);
        fetch(24'h104, 1'b0, 1'b1, 1'b0, 1'b0);
    endtask

    // Watchdog against a hang
    initial begin
        #2500000;
        n_mismatch++;
        end_of_test();
    end

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        drive(1'b0, 24'h000, 1'b0, 1'b0);
        mode_wr_en = 1'b0;
        mode_wr_data = 32'h0000_0000;
        flush_req = 1'b0;
        flush_next_ext = 1'b0;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        sc_reset();
        sc_lru();
        sc_bypass();
        sc_off();
        sc_freeze();
        sc_flush();
        end_of_test();
    end
endmodule // tb
`default_nettype wire
